// >>> hw/wdg_pkg.sv
// constants and types shared by the watchdog malfunction detector
package wdg_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 100;
    // longest watchdog reset, in high-frequency clock periods (MCLK is fc)
    localparam int RST_PULSE_FC_PERIODS = 24;
    localparam int RST_TIME_NS = RST_PULSE_FC_PERIODS * CLK_PERIOD_NS;
    // longest time rounds down to whole cycles
    localparam int RST_CYCLES = RST_TIME_NS / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 5;

    // ************************************************************
    // divider taps: a tap fires once per quarter of the detection time
    // ************************************************************
    localparam int DIV_W = 23;
    localparam int TAP_SEL_W = 5;
    // 2^25 fc cycles / 4 stages -> all ones in bits [22:0]
    localparam int FC_TAP_TOP = 22;
    // 2^17 fs ticks / 4 stages -> all ones in bits [14:0]
    localparam int FS_TAP_TOP = 14;

    // ************************************************************
    // register indices and byte addresses
    // ************************************************************
    localparam logic [7:0] IDX_CTRL_ONE = 8'h34;
    localparam logic [7:0] IDX_CTRL_CODE = 8'h35;
    localparam logic [7:0] IDX_STATUS = 8'h30;
    localparam logic [11:0] ADDR_CTRL_ONE = {2'h0, IDX_CTRL_ONE, 2'h0};
    localparam logic [11:0] ADDR_CTRL_CODE = {2'h0, IDX_CTRL_CODE, 2'h0};
    localparam logic [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};

    // ************************************************************
    // control register one fields and reset value
    // ************************************************************
    localparam int F_OUT_SEL = 0;
    localparam int F_TIME_LO = 1;
    localparam int F_TIME_HI = 2;
    localparam int F_ENABLE = 3;
    localparam int F_TRAP_ACT = 4;
    localparam int F_RAM_TRAP = 5;
    localparam logic [7:0] CTRL_ONE_RST = 8'h39;

    // ************************************************************
    // control codes
    // ************************************************************
    localparam logic [7:0] CODE_CLEAR = 8'h4e;
    localparam logic [7:0] CODE_DISABLE = 8'hb1;
    localparam logic [7:0] CODE_TRAP_AREA = 8'hd2;

    // ************************************************************
    // states
    // ************************************************************
    typedef enum logic [1:0] {
        WDG_RUN = 2'b01,
        WDG_PULSE = 2'b10
    } wdg_state_t;

endpackage

// >>> hw/wdg_divider.sv
// free-running internal divider with a selectable tap pulse
`timescale 1ns/1ns
`default_nettype none
module wdg_divider
    import wdg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic step,
    input wire logic [TAP_SEL_W-1:0] tap_sel,
    output logic tap_pulse
);

    logic [DIV_W-1:0] cnt_r;
    logic [DIV_W-1:0] ones;

    // ************************************************************
    // carry chain: ones[i] says bits [i:0] are all set
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < DIV_W; i++) begin : g_ones
            if (i == 0) begin : g_lsb
                assign ones[i] = cnt_r[0];
            end else begin : g_up
                assign ones[i] = ones[i-1] & cnt_r[i];
            end
        end
    endgenerate

    // never cleared by software, so the first stage may be partly spent
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (step) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // tap fires as the selected low part rolls over
    assign tap_pulse = step & ones[tap_sel];

endmodule
`default_nettype wire

// >>> hw/wdg_bincnt.sv
// two-stage binary counter clocked by the divider tap
`timescale 1ns/1ns
`default_nettype none
module wdg_bincnt
    import wdg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic step,
    output logic [1:0] count,
    output logic wrap
);

    logic [1:0] count_r;

    // clear beats a step arriving in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= 2'h0;
        end else if (clr) begin
            count_r <= 2'h0;
        end else if (step) begin
            count_r <= count_r + 2'h1;
        end
    end

    assign count = count_r;
    // wrap from three to zero is the overflow
    assign wrap = step & ~clr & (count_r == 2'h3);

endmodule
`default_nettype wire

// >>> hw/wdg_top.sv
// watchdog malfunction detector with apb register access
`timescale 1ns/1ns
`default_nettype none
module wdg_top
    import wdg_pkg::*;
#(
    parameter int FC_TAP_BASE = FC_TAP_TOP,
    parameter int FS_TAP_BASE = FS_TAP_TOP
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic LF_TICK,
    input wire logic SLOW_MODE,
    input wire logic SLOW1_MODE,
    input wire logic DIVIDER_CLOCK_SOURCE_BIT,
    input wire logic HOLD_COUNT,
    output logic GUARD_OVERFLOW_INTERRUPT,
    output logic GUARD_RESET_REQ,
    output logic HF_OSC_RESTART,
    output logic RAM_TRAP_SELECT,
    output logic TRAP_ACTION_SELECT
);

    // ************************************************************
    // declarations
    // ************************************************************
    logic access;
    logic hit;
    logic wr_one;
    logic wr_code;
    logic code_clear;
    logic code_disable;
    logic code_trap;
    logic out_sel_r;
    logic [1:0] det_time_r;
    logic en_req_r;
    logic enabled_r;
    logic trap_act_r;
    logic ram_trap_stage_r;
    logic ram_trap_r;
    logic [31:0] prdata_r;
    wdg_state_t state_r;
    logic [RST_CNT_W-1:0] rst_cnt_r;
    logic rst_req_r;
    logic osc_restart_r;
    logic nmi_r;
    logic src_low;
    logic div_step;
    logic [TAP_SEL_W-1:0] tap_base;
    logic [TAP_SEL_W-1:0] tap_sel;
    logic tap_pulse;
    logic cnt_clr;
    logic cnt_step;
    logic [1:0] count;
    logic wrap;
    logic overflow;

    // ************************************************************
    // apb decode
    // ************************************************************
    // zero wait states: every access completes in its first access cycle
    assign access = PSEL & PENABLE;
    assign hit = (PADDR == ADDR_CTRL_ONE) | (PADDR == ADDR_CTRL_CODE) |
                 (PADDR == ADDR_STATUS);
    assign wr_one = access & PWRITE & (PADDR == ADDR_CTRL_ONE);
    assign wr_code = access & PWRITE & (PADDR == ADDR_CTRL_CODE);
    assign code_clear = wr_code & (PWDATA[7:0] == CODE_CLEAR);
    assign code_disable = wr_code & (PWDATA[7:0] == CODE_DISABLE);
    assign code_trap = wr_code & (PWDATA[7:0] == CODE_TRAP_AREA);
    assign PREADY = 1'b1;
    assign PSLVERR = access & ~hit;

    // read data: control registers read as zero, status shows live state
    // write-only read
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            prdata_r <= 32'h0;
        end else if (PSEL & ~PENABLE & ~PWRITE & (PADDR == ADDR_STATUS)) begin
            prdata_r <= {27'h0, rst_req_r, count, enabled_r, out_sel_r};
        end else if (PSEL & ~PENABLE) begin
            prdata_r <= 32'h0;
        end
    end
    assign PRDATA = prdata_r;

    // ************************************************************
    // control register one
    // ************************************************************
    // output select only moves toward interrupt
    // write once
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            out_sel_r <= CTRL_ONE_RST[F_OUT_SEL];
        end else if (wr_one) begin
            out_sel_r <= out_sel_r & PWDATA[F_OUT_SEL];
        end
    end

    // detection time, trap action and staged ram trap bit
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            det_time_r <= CTRL_ONE_RST[F_TIME_HI:F_TIME_LO];
            trap_act_r <= CTRL_ONE_RST[F_TRAP_ACT];
            ram_trap_stage_r <= CTRL_ONE_RST[F_RAM_TRAP];
            en_req_r <= CTRL_ONE_RST[F_ENABLE];
        end else if (wr_one) begin
            det_time_r <= PWDATA[F_TIME_HI:F_TIME_LO];
            trap_act_r <= PWDATA[F_TRAP_ACT];
            ram_trap_stage_r <= PWDATA[F_RAM_TRAP];
            en_req_r <= PWDATA[F_ENABLE];
        end
    end

    // zero in the enable bit alone does not stop the watchdog
    // enable on one
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            enabled_r <= CTRL_ONE_RST[F_ENABLE];
        end else if (wr_one & PWDATA[F_ENABLE]) begin
            enabled_r <= 1'b1;
        end else if (code_disable & ~en_req_r) begin
            enabled_r <= 1'b0;
        end
    end

    // staged trap area selection is applied only by its code
    // trap arm
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ram_trap_r <= CTRL_ONE_RST[F_RAM_TRAP];
        end else if (code_trap) begin
            ram_trap_r <= ram_trap_stage_r;
        end
    end
    assign RAM_TRAP_SELECT = ram_trap_r;
    assign TRAP_ACTION_SELECT = trap_act_r;

    // ************************************************************
    // divider and binary counter
    // ************************************************************
    // tap select
    assign src_low = SLOW_MODE | DIVIDER_CLOCK_SOURCE_BIT;
    assign tap_base = src_low ? TAP_SEL_W'(FS_TAP_BASE) : TAP_SEL_W'(FC_TAP_BASE);
    assign tap_sel = tap_base - {2'h0, det_time_r, 1'b0};
    assign div_step = ~HOLD_COUNT & (src_low ? LF_TICK : 1'b1);

    wdg_divider u_div (
        .clk(MCLK),
        .rst_n(RST_N),
        .step(div_step),
        .tap_sel(tap_sel),
        .tap_pulse(tap_pulse)
    );

    assign cnt_clr = code_clear | ~enabled_r | (state_r != WDG_RUN);
    assign cnt_step = tap_pulse & enabled_r;

    wdg_bincnt u_cnt (
        .clk(MCLK),
        .rst_n(RST_N),
        .clr(cnt_clr),
        .step(cnt_step),
        .count(count),
        .wrap(wrap)
    );

    assign overflow = wrap & (state_r == WDG_RUN);

    // ************************************************************
    // overflow actions
    // ************************************************************
    // interrupt is a one-cycle pulse, never gated by any mask
    // interrupt select
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            nmi_r <= 1'b0;
        end else begin
            nmi_r <= overflow & ~out_sel_r;
        end
    end
    assign GUARD_OVERFLOW_INTERRUPT = nmi_r;

    // reset pulse sequencer; counter stays cleared while it runs
    // reset select
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= WDG_RUN;
            rst_cnt_r <= '0;
            rst_req_r <= 1'b0;
        end else begin
            case (state_r)
                WDG_RUN: begin
                    if (overflow & out_sel_r) begin
                        state_r <= WDG_PULSE;
                        rst_cnt_r <= '0;
                        rst_req_r <= 1'b1;
                    end
                end
                WDG_PULSE: begin
                    if (rst_cnt_r == RST_CNT_W'(RST_CYCLES - 1)) begin
                        state_r <= WDG_RUN;
                        rst_req_r <= 1'b0;
                    end else begin
                        rst_cnt_r <= rst_cnt_r + 1'b1;
                    end
                end
                default: begin
                    state_r <= WDG_RUN;
                    rst_req_r <= 1'b0;
                end
            endcase
        end
    end
    assign GUARD_RESET_REQ = rst_req_r;

    // slow1 stops fc, so the reset must restart it to be timed in fc
    // oscillator restart
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            osc_restart_r <= 1'b0;
        end else if (state_r == WDG_RUN) begin
            osc_restart_r <= overflow & out_sel_r & SLOW1_MODE;
        end else if (rst_cnt_r == RST_CNT_W'(RST_CYCLES - 1)) begin
            osc_restart_r <= 1'b0;
        end
    end
    assign HF_OSC_RESTART = osc_restart_r;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    sequence s_ovf_reset;
        overflow && out_sel_r;
    endsequence

    sequence s_pulse_tail;
        ##23 rst_req_r ##1 !rst_req_r;
    endsequence

    property p_ovf_reset;
        s_ovf_reset |=> rst_req_r && !nmi_r;
    endproperty
    a_ovf_reset: assert property (p_ovf_reset)
        else $error("overflow with reset select gave no reset");

    property p_ovf_irq;
        overflow && !out_sel_r |=> nmi_r ##1 !nmi_r && !rst_req_r;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq)
        else $error("overflow with interrupt select gave no single pulse");

    property p_reset_len;
        $rose(rst_req_r) |-> s_pulse_tail;
    endproperty
    a_reset_len: assert property (p_reset_len)
        else $error("watchdog reset length is not 24 cycles");

    property p_sel_once;
        !out_sel_r |=> !out_sel_r;
    endproperty
    a_sel_once: assert property (p_sel_once)
        else $error("output select returned to reset");

    property p_hold;
        HOLD_COUNT && !code_clear && enabled_r && state_r == WDG_RUN |=> $stable(count);
    endproperty
    a_hold: assert property (p_hold)
        else $error("counter moved in a low-power mode");

    property p_clear;
        code_clear |=> count == 2'h0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear code left the counter set");

    property p_disable_gate;
        code_disable && en_req_r && enabled_r |=> enabled_r;
    endproperty
    a_disable_gate: assert property (p_disable_gate)
        else $error("disable code acted with enable bit set");

    property p_disabled_clear;
        !enabled_r |=> count == 2'h0 && !overflow;
    endproperty
    a_disabled_clear: assert property (p_disabled_clear)
        else $error("counter not held cleared while disabled");

    property p_trap_arm;
        !code_trap |=> $stable(ram_trap_r);
    endproperty
    a_trap_arm: assert property (p_trap_arm)
        else $error("ram trap select changed without its code");

    property p_enable_one;
        wr_one && PWDATA[F_ENABLE] |=> enabled_r;
    endproperty
    a_enable_one: assert property (p_enable_one)
        else $error("writing one did not enable the watchdog");

endmodule
`default_nettype wire

// >>> tb/wdg_top_tb_top.sv
// self-checking bench for the watchdog malfunction detector
`timescale 1ns/1ns
`default_nettype none
module wdg_top_tb_top;
    import wdg_pkg::*;
    // shortened tap bases keep every detection time short
    localparam int FCB = 6;
    localparam int FSB = 6;
    logic MCLK = 1'b0;
    logic RST_N = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h0;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, GUARD_OVERFLOW_INTERRUPT, GUARD_RESET_REQ, HF_OSC_RESTART;
    logic RAM_TRAP_SELECT, TRAP_ACTION_SELECT;
    logic LF_TICK = 1'b0;
    logic SLOW_MODE = 1'b0;
    logic SLOW1_MODE = 1'b0;
    logic DIVIDER_CLOCK_SOURCE_BIT = 1'b0;
    logic HOLD_COUNT = 1'b0;
    logic lf_on = 1'b0;
    logic [2:0] lf_cnt = 3'h0;
    int miscompares = 0;
    int n_checks = 0;
    int n_irq = 0;
    int n_rsthi = 0;

    wdg_top #(.FC_TAP_BASE(FCB), .FS_TAP_BASE(FSB)) u_wdg_top (
        .MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .LF_TICK(LF_TICK), .SLOW_MODE(SLOW_MODE),
        .SLOW1_MODE(SLOW1_MODE), .DIVIDER_CLOCK_SOURCE_BIT(DIVIDER_CLOCK_SOURCE_BIT),
        .HOLD_COUNT(HOLD_COUNT), .GUARD_OVERFLOW_INTERRUPT(GUARD_OVERFLOW_INTERRUPT),
        .GUARD_RESET_REQ(GUARD_RESET_REQ), .HF_OSC_RESTART(HF_OSC_RESTART),
        .RAM_TRAP_SELECT(RAM_TRAP_SELECT), .TRAP_ACTION_SELECT(TRAP_ACTION_SELECT)
    );

    // ****************************************
    // clock, slow tick and event counters
    // ****************************************
    initial begin
        forever #(CLK_PERIOD_NS / 2) MCLK = ~MCLK;
    end

    // slow tick every eighth cycle, so fs periods differ from fc periods
    always @(posedge MCLK) begin
        lf_cnt <= lf_cnt + 3'h1;
        LF_TICK <= lf_on && (lf_cnt == 3'h7);
    end

    // sampled on the falling edge where registered outputs are settled
    always @(negedge MCLK) begin
        if (GUARD_OVERFLOW_INTERRUPT === 1'b1) n_irq++;
        if (GUARD_RESET_REQ === 1'b1) n_rsthi++;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    function automatic int per(int b, int t);
        return 1 << (b - 2 * t + 3);
    endfunction

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge MCLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= {24'h0, d};
        @(posedge MCLK);
        PENABLE <= 1'b1;
        // no wait count assumed: only the watchdog process ends a hang
        do begin
            @(posedge MCLK);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 8'h0, r, e);
    endtask

    task automatic do_reset();
        @(posedge MCLK);
        RST_N <= 1'b0;
        repeat (5) @(posedge MCLK);
        RST_N <= 1'b1;
    endtask

    // bounded wait for interrupt (0) or reset request (1)
    task automatic wait_hi(input int which, input int lim);
        int i;
        i = 0;
        do begin
            @(negedge MCLK);
            i++;
        end while ((which ? GUARD_RESET_REQ : GUARD_OVERFLOW_INTERRUPT) !== 1'b1 && i < lim);
        chk("overflow seen", 1, 32'(i < lim));
    endtask

    // skips one pulse since a tap change shortens the first interval
    task automatic irq_gap(input int exp);
        int g;
        wait_hi(0, 4 * exp + 20);
        wait_hi(0, 4 * exp + 20);
        @(negedge MCLK);
        chk("irq width", 0, 32'(GUARD_OVERFLOW_INTERRUPT));
        g = 1;
        while (GUARD_OVERFLOW_INTERRUPT !== 1'b1 && g < 4000) begin
            @(negedge MCLK);
            g++;
        end
        chk("irq period", exp, g);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_defaults();
        logic [31:0] r;
        logic e;
        rd(ADDR_STATUS, r);
        chk("status after reset", 32'h3, r);
        rd(ADDR_CTRL_ONE, r);
        chk("ctrl one read", 32'h0, r);
        apb(1'b0, 12'h100, 8'h0, r, e);
        chk("unmapped error", 1, 32'(e));
        @(negedge MCLK);
        chk("ram trap after reset", 1, 32'(RAM_TRAP_SELECT));
        chk("trap action after reset", 1, 32'(TRAP_ACTION_SELECT));
    endtask

    task automatic t_reset_pulse();
        int n;
        @(posedge MCLK);
        SLOW1_MODE <= 1'b1;
        wr(ADDR_CTRL_ONE, 8'h3f);
        wait_hi(1, per(FCB, 0) + 40);
        chk("osc restart", 1, 32'(HF_OSC_RESTART));
        n = 0;
        while (GUARD_RESET_REQ === 1'b1 && n < 100) begin
            @(negedge MCLK);
            n++;
        end
        chk("reset length", RST_PULSE_FC_PERIODS, n);
        chk("no irq in reset mode", 0, n_irq);
        @(posedge MCLK);
        SLOW1_MODE <= 1'b0;
    endtask

    task automatic t_irq();
        int h;
        logic [31:0] r;
        // stack set up is the cpu's; the select is cleared only once here
        wr(ADDR_CTRL_ONE, 8'h3e);
        irq_gap(per(FCB, 3));
        wr(ADDR_CTRL_ONE, 8'h3c);
        irq_gap(per(FCB, 2));
        wr(ADDR_CTRL_ONE, 8'h3f);
        h = n_rsthi;
        irq_gap(per(FCB, 3));
        chk("no reset after lock", h, n_rsthi);
        rd(ADDR_STATUS, r);
        chk("output select locked", 0, 32'(r[0]));
    endtask

    task automatic t_slow();
        @(posedge MCLK);
        lf_on <= 1'b1;
        DIVIDER_CLOCK_SOURCE_BIT <= 1'b1;
        irq_gap(8 * per(FSB, 3));
        @(posedge MCLK);
        DIVIDER_CLOCK_SOURCE_BIT <= 1'b0;
        SLOW_MODE <= 1'b1;
        irq_gap(8 * per(FSB, 3));
        @(posedge MCLK);
        SLOW_MODE <= 1'b0;
        lf_on <= 1'b0;
    endtask

    task automatic t_clear();
        int h;
        logic [7:0] bad [4];
        bad = '{8'h00, 8'h4f, 8'hb0, 8'hff};
        // clears come from the main flow, never from an interrupt routine
        wr(ADDR_CTRL_CODE, CODE_CLEAR);
        wr(ADDR_CTRL_CODE, CODE_CLEAR);
        h = n_irq;
        repeat (12) wr(ADDR_CTRL_CODE, CODE_CLEAR);
        chk("irq while cleared", h, n_irq);
        h = n_irq;
        for (int i = 0; i < 12; i++) wr(ADDR_CTRL_CODE, bad[i % 4]);
        chk("irq with invalid codes", 1, 32'(n_irq > h));
    endtask

    task automatic t_hold();
        int h;
        logic [31:0] r, r2;
        wr(ADDR_CTRL_CODE, CODE_CLEAR);
        @(posedge MCLK);
        HOLD_COUNT <= 1'b1;
        rd(ADDR_STATUS, r);
        h = n_irq;
        repeat (100) @(posedge MCLK);
        rd(ADDR_STATUS, r2);
        chk("held count", 32'(r[3:2]), 32'(r2[3:2]));
        chk("irq while held", h, n_irq);
        HOLD_COUNT <= 1'b0;
        wait_hi(0, 20);
    endtask

    task automatic t_disable();
        int h;
        logic [31:0] r;
        wr(ADDR_CTRL_CODE, CODE_DISABLE);
        rd(ADDR_STATUS, r);
        chk("disable refused", 1, 32'(r[1]));
        wr(ADDR_CTRL_CODE, CODE_CLEAR);
        wr(ADDR_CTRL_ONE, 8'h36);
        wr(ADDR_CTRL_CODE, CODE_DISABLE);
        rd(ADDR_STATUS, r);
        chk("disabled and cleared", 0, 32'(r[3:1]));
        h = n_irq;
        repeat (100) @(posedge MCLK);
        rd(ADDR_STATUS, r);
        chk("count held clear", 0, 32'(r[3:2]));
        chk("irq while disabled", h, n_irq);
        wr(ADDR_CTRL_ONE, 8'h3e);
        rd(ADDR_STATUS, r);
        chk("enabled by write", 1, 32'(r[1]));
        wait_hi(0, 20);
    endtask

    task automatic t_trap();
        wr(ADDR_CTRL_ONE, 8'h0e);
        @(negedge MCLK);
        chk("ram trap staged", 1, 32'(RAM_TRAP_SELECT));
        chk("trap action written", 0, 32'(TRAP_ACTION_SELECT));
        wr(ADDR_CTRL_CODE, CODE_TRAP_AREA);
        @(negedge MCLK);
        chk("ram trap applied", 0, 32'(RAM_TRAP_SELECT));
    endtask

    // hang guard sized well above the whole sequence
    initial begin
        #(CLK_PERIOD_NS * 30000);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        do_reset();
        t_defaults();
        t_reset_pulse();
        t_irq();
        t_slow();
        t_clear();
        t_hold();
        t_disable();
        t_trap();
        do_reset();
        t_defaults();
        tally_and_finish();
    end
endmodule
`default_nettype wire
